// >>> rtl/charger_map.svh
`ifndef CHARGER_MAP_SVH
`define CHARGER_MAP_SVH

// Command codes and slave address
`define SLAVE_ADDR          7'h12
`define CMD_SPEC_WORD       8'h11
`define CMD_MODE_WORD       8'h12

// Specification word layout
`define SPEC_VERSION_LSB    0
`define SPEC_VERSION_MSB    3
`define SPEC_VERSION_VAL    4'h1
`define SPEC_SELECTOR_BIT   4
`define SPEC_SELECTOR_VAL   1'b0

// Mode word field positions
`define MODE_INHIBIT_BIT    0
`define MODE_POLL_BIT       1
`define MODE_DEFAULTS_BIT   2
`define MODE_ZEROING_BIT    3
`define MODE_LINE_MASK_BIT  4
`define MODE_PACK_MASK_BIT  5
`define MODE_SRC_MASK_BIT   6
`define MODE_OVERTEMP_SHUTOFF_ENABLE_BIT   10

// Reset values
`define RST_INHIBIT         1'b0
`define RST_IRQ_MASK        1'b0
`define RST_OVERTEMP_SHUTOFF_ENABLE        1'b1
`define DEF_VOLTAGE_SET     16'hffff
`define DEF_CURRENT_SET     16'h00c0

`endif

// >>> rtl/charger_pkg.sv
package charger_pkg;

  // Data word carried by a command
  typedef logic [15:0] word_type;

  // Command code byte
  typedef logic [7:0]  cmd_type;

endpackage : charger_pkg

// >>> rtl/setpoint_if.sv
// Set-point storage link between the mode logic and the store
interface setpoint_if;
  import charger_pkg::*;
  logic     load_defaults;
  word_type voltage_setpoint;
  word_type current_setpoint;

  modport store (input load_defaults, output voltage_setpoint, output current_setpoint);
  modport user  (output load_defaults, input voltage_setpoint, input current_setpoint);
endinterface : setpoint_if

// >>> rtl/setpoint_store.sv
`include "charger_map.svh"

// Charge voltage and current set points
module setpoint_store
  import charger_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  rst_n,
  setpoint_if.store  sp
);

  // Defaults at reset and on a defaults action
  always_ff @(posedge clock) begin
    if (!rst_n || sp.load_defaults) begin
      sp.voltage_setpoint <= `DEF_VOLTAGE_SET;
      sp.current_setpoint <= `DEF_CURRENT_SET;
    end
  end

endmodule : setpoint_store

// >>> rtl/edge_watch.sv
// Either-edge detector with mask, primed one cycle after reset
module edge_watch (
  input  wire logic level_in,
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic mask,
  output logic      change_pulse,
  output logic      fall_pulse
);

  logic prev_reg;
  logic primed_reg;

  // Previous level and first-sample guard
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prev_reg   <= 1'b0;
      primed_reg <= 1'b0;
    end else begin
      prev_reg   <= level_in;
      primed_reg <= 1'b1;
    end
  end

  // Unmasked change and raw falling edge
  assign change_pulse = primed_reg && (level_in != prev_reg) && !mask;
  assign fall_pulse   = primed_reg && prev_reg && !level_in;

endmodule : edge_watch

// >>> rtl/charger_spec_and_mode_regs.sv
// Functional notes
// - Spec word read returns version 1 in bits 3..0.
// - Spec word bit 4 reads zero, no selector; bits 15..5 read zero.
// - Mode write bit 0 sets or clears the charge inhibit flip-flop.
// - Charge inhibit changes only through mode write bit 0.
// - Mode bit 2 loads default set points, clears overtemp and alarm latches.
// - Line power changes interrupt unless mode bit 4 masks them.
// - Pack present changes interrupt unless mode bit 5 masks them.
// - Source below pack changes interrupt unless mode bit 6 masks them.
// - With mode bit 10 set, overtemp latch turns charger off.
// - Overtemp latch clears on defaults action or pack absent.
// - After reset: inhibit clear, masks clear, overtemp shutoff enabled.
// - Spec word read uses command 0x11 at slave address 0x12.
// - Mode word write uses command 0x12, low byte first.
// - Pack removal sets overtemp shutoff enable back to one.
`include "charger_map.svh"

module charger_spec_and_mode_regs
  import charger_pkg::*;
(
  input  wire logic     clock,
  input  wire logic     rst_n,
  input  wire logic     cmd_valid,
  input  wire logic     cmd_write,
  input  wire cmd_type  cmd_code,
  input  wire word_type cmd_wdata,
  output logic          rsp_valid,
  output logic          rsp_ack,
  output word_type      rsp_rdata,
  input  wire logic     line_power_detect,
  input  wire logic     pack_present,
  input  wire logic     source_below_pack,
  input  wire logic     overtemp_detect,
  input  wire logic     alarm_inhibit_set,
  output logic          charge_inhibit,
  output logic          charge_stop,
  output logic          overtemp_latch,
  output logic          alarm_inhibit,
  output logic          overtemp_shutoff_enable,
  output logic          line_power_irq_mask,
  output logic          pack_irq_mask,
  output logic          source_irq_mask,
  output word_type      voltage_setpoint,
  output word_type      current_setpoint,
  output logic          irq_pulse
);

  logic     spec_read;
  logic     mode_write;
  logic     defaults_req;
  logic     line_change;
  logic     pack_change;
  logic     pack_removed;
  logic     src_change;
  word_type spec_word;

  setpoint_if sp ();

  // Command decode; the word arrives already assembled low byte first
  assign spec_read    = cmd_valid && !cmd_write && (cmd_code == `CMD_SPEC_WORD);
  assign mode_write   = cmd_valid && cmd_write && (cmd_code == `CMD_MODE_WORD);
  assign defaults_req = mode_write && cmd_wdata[`MODE_DEFAULTS_BIT];

  // Fixed specification word, reserved bits zero
  always_comb begin
    spec_word = 16'h0000;
    spec_word[`SPEC_VERSION_MSB:`SPEC_VERSION_LSB] = `SPEC_VERSION_VAL;
    spec_word[`SPEC_SELECTOR_BIT] = `SPEC_SELECTOR_VAL;
  end

  // Answer one cycle after each command; unknown or wrong-way codes get no ack
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_ack   <= 1'b0;
      rsp_rdata <= 16'h0000;
    end else begin
      rsp_valid <= cmd_valid;
      rsp_ack   <= spec_read || mode_write;
      rsp_rdata <= spec_read ? spec_word : 16'h0000;
    end
  end

  // Charge inhibit, touched by nothing but mode bit 0
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      charge_inhibit <= `RST_INHIBIT;
    end else if (mode_write) begin
      charge_inhibit <= cmd_wdata[`MODE_INHIBIT_BIT];
    end
  end

  // Interrupt masks; bits 1, 3, 7-9, 11-15 are never looked at
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      line_power_irq_mask <= `RST_IRQ_MASK;
      pack_irq_mask       <= `RST_IRQ_MASK;
      source_irq_mask     <= `RST_IRQ_MASK;
    end else if (mode_write) begin
      line_power_irq_mask <= cmd_wdata[`MODE_LINE_MASK_BIT];
      pack_irq_mask       <= cmd_wdata[`MODE_PACK_MASK_BIT];
      source_irq_mask     <= cmd_wdata[`MODE_SRC_MASK_BIT];
    end
  end

  // Overtemp shutoff enable; a pack removal beats a write in the same cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      overtemp_shutoff_enable <= `RST_OVERTEMP_SHUTOFF_ENABLE;
    end else if (pack_removed) begin
      overtemp_shutoff_enable <= `RST_OVERTEMP_SHUTOFF_ENABLE;
    end else if (mode_write) begin
      overtemp_shutoff_enable <= cmd_wdata[`MODE_OVERTEMP_SHUTOFF_ENABLE_BIT];
    end
  end

  // Overtemp latch; a hot reading wins over any clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      overtemp_latch <= 1'b0;
    end else if (overtemp_detect) begin
      overtemp_latch <= 1'b1;
    end else if (defaults_req || !pack_present) begin
      overtemp_latch <= 1'b0;
    end
  end

  // Alarm inhibit latch; the set event wins over a clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      alarm_inhibit <= 1'b0;
    end else if (alarm_inhibit_set) begin
      alarm_inhibit <= 1'b1;
    end else if (defaults_req || !pack_present) begin
      alarm_inhibit <= 1'b0;
    end
  end

  // Charger off from inhibit or from a gated overtemp latch
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      charge_stop <= 1'b0;
    end else begin
      charge_stop <= charge_inhibit || (overtemp_shutoff_enable && overtemp_latch);
    end
  end

  // Set-point store, reloaded by the defaults action
  assign sp.load_defaults = defaults_req;
  assign voltage_setpoint = sp.voltage_setpoint;
  assign current_setpoint = sp.current_setpoint;

  setpoint_store u_setpoints (
    .clock (clock),
    .rst_n (rst_n),
    .sp    (sp.store)
  );

  // Status edge watchers, one per maskable status
  edge_watch u_line_edge (
    .level_in     (line_power_detect),
    .clock        (clock),
    .rst_n        (rst_n),
    .mask         (line_power_irq_mask),
    .change_pulse (line_change),
    .fall_pulse   ()
  );

  edge_watch u_pack_edge (
    .level_in     (pack_present),
    .clock        (clock),
    .rst_n        (rst_n),
    .mask         (pack_irq_mask),
    .change_pulse (pack_change),
    .fall_pulse   (pack_removed)
  );

  edge_watch u_src_edge (
    .level_in     (source_below_pack),
    .clock        (clock),
    .rst_n        (rst_n),
    .mask         (source_irq_mask),
    .change_pulse (src_change),
    .fall_pulse   ()
  );

  // One-cycle interrupt pulse for any unmasked change
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_pulse <= 1'b0;
    end else begin
      irq_pulse <= line_change || pack_change || src_change;
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  logic primed_chk_reg;

  // Marks cycles whose previous sample is valid
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      primed_chk_reg <= 1'b0;
    end else begin
      primed_chk_reg <= 1'b1;
    end
  end

  a_spec_read_value: assert property (
    spec_read |=> rsp_valid && rsp_ack && (rsp_rdata[3:0] == 4'h1))
    else $error("spec word version field wrong");

  a_spec_upper_zero: assert property (
    spec_read |=> (rsp_rdata[15:4] == 12'h000))
    else $error("spec word upper bits not zero");

  a_inhibit_follows: assert property (
    mode_write |=> (charge_inhibit == $past(cmd_wdata[0])))
    else $error("inhibit does not follow mode bit 0");

  a_inhibit_only_mode: assert property (
    !mode_write |=> $stable(charge_inhibit))
    else $error("inhibit changed without mode write");

  a_defaults_load: assert property (
    defaults_req |=> (voltage_setpoint == 16'hffff) && (current_setpoint == 16'h00c0)
                     && (alarm_inhibit == $past(alarm_inhibit_set)))
    else $error("defaults action did not reload set points");

  a_line_irq_raise: assert property (
    primed_chk_reg && !line_power_irq_mask && $changed(line_power_detect) |=> irq_pulse)
    else $error("line power change missed interrupt");

  a_pack_irq_raise: assert property (
    primed_chk_reg && !pack_irq_mask && $changed(pack_present) |=> irq_pulse)
    else $error("pack change missed interrupt");

  a_src_irq_raise: assert property (
    primed_chk_reg && !source_irq_mask && $changed(source_below_pack) |=> irq_pulse)
    else $error("source change missed interrupt");

  a_irq_has_cause: assert property (
    irq_pulse |-> ($past(!line_power_irq_mask)
                   && ($past(line_power_detect) != $past(line_power_detect, 2)))
                  || ($past(!pack_irq_mask)
                   && ($past(pack_present) != $past(pack_present, 2)))
                  || ($past(!source_irq_mask)
                   && ($past(source_below_pack) != $past(source_below_pack, 2))))
    else $error("interrupt without unmasked change");

  a_overtemp_shutoff_enable_off: assert property (
    overtemp_shutoff_enable && overtemp_latch |=> charge_stop)
    else $error("overtemp latch failed to stop charger");

  a_hot_no_effect: assert property (
    !overtemp_shutoff_enable && !charge_inhibit |=> !charge_stop)
    else $error("charger stopped without cause");

  a_hot_clear_removal: assert property (
    !pack_present && !overtemp_detect |=> !overtemp_latch)
    else $error("overtemp latch not cleared");

  a_reset_defaults: assert property (
    $rose(rst_n) |-> !charge_inhibit && !line_power_irq_mask && !pack_irq_mask
                     && !source_irq_mask && overtemp_shutoff_enable)
    else $error("wrong state after reset");

  a_removal_reenable: assert property (
    primed_chk_reg && $fell(pack_present) |=> overtemp_shutoff_enable)
    else $error("pack removal did not re-enable shutoff");

  a_unused_ignored: assert property (
    mode_write && !cmd_wdata[2] |=> $stable(voltage_setpoint) && $stable(current_setpoint))
    else $error("unused mode bits caused a side effect");

  a_unused_latch_kept: assert property (
    mode_write && !cmd_wdata[2] && !overtemp_detect && pack_present
    |=> (overtemp_latch == $past(overtemp_latch)))
    else $error("mode write without defaults touched overtemp latch");

  a_refused_no_ack: assert property (
    cmd_valid && !spec_read && !mode_write |=> rsp_valid && !rsp_ack && (rsp_rdata == 16'h0000))
    else $error("refused command was acknowledged");

  a_mode_write_ack: assert property (
    mode_write |=> rsp_valid && rsp_ack)
    else $error("mode word write not acknowledged");

  a_defaults_hot_clear: assert property (
    defaults_req && !overtemp_detect |=> !overtemp_latch)
    else $error("defaults action left overtemp latch set");

  a_masks_follow: assert property (
    mode_write |=> ({source_irq_mask, pack_irq_mask, line_power_irq_mask} == $past(cmd_wdata[6:4])))
    else $error("interrupt masks do not follow mode write");

  a_shutoff_write: assert property (
    mode_write && !pack_removed |=> (overtemp_shutoff_enable == $past(cmd_wdata[10])))
    else $error("host could not change overtemp shutoff enable");

  c_spec_read:  cover property (spec_read ##1 rsp_ack);
  c_defaults:   cover property (defaults_req ##1 (current_setpoint == 16'h00c0));
  c_masked_irq: cover property (line_power_irq_mask && $changed(line_power_detect));
  c_overtemp_shutoff_enable:   cover property (overtemp_latch && overtemp_shutoff_enable ##1 charge_stop);
  c_removal:    cover property (pack_removed ##1 overtemp_shutoff_enable);

endmodule : charger_spec_and_mode_regs

// >>> bench/host_model.sv
// Host side of the command port: one word per command
module host_model
  import charger_pkg::*;
(
  input  wire logic     clock,
  output logic          cmd_valid,
  output logic          cmd_write,
  output cmd_type       cmd_code,
  output word_type      cmd_wdata,
  input  wire logic     rsp_valid,
  input  wire logic     rsp_ack,
  input  wire word_type rsp_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // Request held to the taking edge, then released with inverted lines
  task automatic issue(input logic wr, input cmd_type code, input word_type data,
                       input int gap, output logic [1:0] rsp, output word_type rd);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_code  <= code;
    cmd_wdata <= data;
    @(posedge clock);
    cmd_valid <= 1'b0;
    cmd_write <= ~wr;
    cmd_code  <= ~code;
    cmd_wdata <= ~data;
    #1;
    rsp = {rsp_valid, rsp_ack};
    rd  = rsp_rdata;
  endtask : issue
endmodule : host_model

// >>> bench/tb_top.sv
`include "charger_map.svh"

module tb_top;
  import charger_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clock = 1'b0;
  logic        rst_n, cmd_valid, cmd_write, rsp_valid, rsp_ack;
  cmd_type     cmd_code;
  word_type    cmd_wdata, rsp_rdata, voltage_setpoint, current_setpoint, rd, w;
  logic        line_power_detect, pack_present, source_below_pack;
  logic        overtemp_detect, alarm_inhibit_set, charge_inhibit, charge_stop;
  logic        overtemp_latch, alarm_inhibit, overtemp_shutoff_enable;
  logic        line_power_irq_mask, pack_irq_mask, source_irq_mask, irq_pulse;
  logic [1:0]  rsp;
  logic [31:0] seed = 32'h0000_0041;
  int          fails = 0;
  int          tests_run = 0;
  int          cycles = 0;

  // Clock
  always #25 clock = ~clock;

  charger_spec_and_mode_regs charger_spec_and_mode_regs_i (
    .clock, .rst_n, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata, .rsp_valid,
    .rsp_ack, .rsp_rdata, .line_power_detect, .pack_present, .source_below_pack,
    .overtemp_detect, .alarm_inhibit_set, .charge_inhibit, .charge_stop,
    .overtemp_latch, .alarm_inhibit, .overtemp_shutoff_enable, .line_power_irq_mask,
    .pack_irq_mask, .source_irq_mask, .voltage_setpoint, .current_setpoint, .irq_pulse
  );

  host_model host_model_i (
    .clock, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata, .rsp_valid, .rsp_ack,
    .rsp_rdata
  );

  // Random source
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  // Mode fields as observed and as expected from a written word
  function automatic word_type fields();
    return {11'h000, overtemp_shutoff_enable, source_irq_mask, pack_irq_mask,
            line_power_irq_mask, charge_inhibit};
  endfunction : fields

  function automatic word_type mode_exp(input word_type d);
    return {11'h000, d[`MODE_OVERTEMP_SHUTOFF_ENABLE_BIT], d[6:4], d[`MODE_INHIBIT_BIT]};
  endfunction : mode_exp

  task automatic chk(input string name, input word_type seen, input word_type exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // One command with a random idle gap
  task automatic cmd(input logic wr, input cmd_type code, input word_type data);
    seed = xs(seed);
    host_model_i.issue(wr, code, data, int'(seed[0]), rsp, rd);
  endtask : cmd

  // Hot reading and alarm set for one cycle, then settle
  task automatic hot();
    @(posedge clock);
    overtemp_detect   <= 1'b1;
    alarm_inhibit_set <= 1'b1;
    @(posedge clock);
    overtemp_detect   <= 1'b0;
    alarm_inhibit_set <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask : hot

  // Toggle one status line and count pulses
  task automatic irq_try(input int k, input logic m);
    int n;
    n = 0;
    cmd(1'b1, `CMD_MODE_WORD, 16'h0400 | (16'(m) << (4 + k)));
    @(posedge clock);
    case (k)
      0: line_power_detect <= ~line_power_detect;
      1: pack_present <= ~pack_present;
      default: source_below_pack <= ~source_below_pack;
    endcase
    repeat (4) begin
      @(posedge clock);
      #1;
      if (irq_pulse === 1'b1) n++;
    end
    chk("irq count", 16'(n), m ? 16'h0000 : 16'h0001);
  endtask : irq_try

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      results();
    end
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    line_power_detect = 1'b0;
    pack_present = 1'b1;
    source_below_pack = 1'b0;
    overtemp_detect = 1'b0;
    alarm_inhibit_set = 1'b0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    chk("reset fields", fields(), 16'h0010);
    cmd(1'b0, `CMD_SPEC_WORD, 16'h0000);
    chk("spec rsp", 16'(rsp), 16'h0003);
    chk("spec word", rd, 16'h0001);
    for (int i = 0; i < 3; i++) begin
      cmd(i != 1, (i == 1) ? 8'h12 : 8'h11 + 8'(i), 16'hffff);
      chk("bad rsp", 16'(rsp), 16'h0002);
      chk("bad fields", fields(), 16'h0010);
    end
    $display("test spec done");
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      w = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : seed[15:0];
      cmd(1'b1, `CMD_MODE_WORD, w);
      chk("mode rsp", 16'(rsp), 16'h0003);
      chk("mode fields", fields(), mode_exp(w));
      @(posedge clock);
      #1;
      chk("stop", 16'(charge_stop), 16'(w[0]));
      cmd(1'b0, `CMD_SPEC_WORD, ~w);
      chk("kept", fields(), mode_exp(w));
    end
    $display("test mode done");
    for (int k = 0; k < 3; k++) begin
      irq_try(k, 1'b0);
      irq_try(k, 1'b1);
    end
    $display("test irq done");
    cmd(1'b1, `CMD_MODE_WORD, 16'h0400);
    hot();
    chk("overtemp_shutoff_enable", 16'({overtemp_latch, alarm_inhibit, charge_stop}), 16'h0007);
    cmd(1'b1, `CMD_MODE_WORD, 16'h0004);
    chk("defaults", 16'({overtemp_latch, alarm_inhibit}), 16'h0000);
    chk("volt", voltage_setpoint, 16'hffff);
    chk("curr", current_setpoint, 16'h00c0);
    hot();
    chk("hot run", 16'({overtemp_latch, charge_stop}), 16'h0002);
    @(posedge clock);
    pack_present <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    chk("pack out", 16'({overtemp_latch, overtemp_shutoff_enable}), 16'h0001);
    $display("test hot done");
    results();
  end
endmodule : tb_top
